// ==== design/pwm_core_pkg.sv ====
// Purpose: Shared constants and types for the PWM oscillator core
// Assumes: One master oscillator period equals one ref_clk cycle
// Notes: Levels are in thousandths of the set reference level
package pwm_core_pkg;

    // ----------------------------------------
    // Register map (APB byte addresses)
    // ----------------------------------------
    localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
    localparam logic [31:0] ADDR_DUTY = 32'h0000_0008;
    localparam int CTRL_MODE_LSB = 0;
    localparam int ST_RUN_BIT = 0;
    localparam int ST_CODE_LSB = 4;
    localparam int ST_POL_BIT = 8;
    localparam int ST_PEND_BIT = 9;
    localparam int DUTY_LSB = 0;

    // ----------------------------------------
    // Duty transfer
    // ----------------------------------------
    localparam logic [9:0] LVL_LO = 10'h064;
    localparam logic [9:0] LVL_HI = 10'h384;
    localparam logic [12:0] DUTY_NUM = 13'h0005;
    localparam logic [12:0] DUTY_DEN = 13'h0004;
    localparam logic [24:0] DUTY_FULL = 25'h00003E8;
    localparam logic [9:0] DUTY_MIN_CLAMP = 10'h032;
    localparam logic [9:0] DUTY_MAX_CLAMP = 10'h3B6;

    // ----------------------------------------
    // Divider and timing
    // ----------------------------------------
    localparam int RATIO_LOG_STEP = 2;
    localparam int MASTER_CLKS_PER_PERIOD = 1;
    localparam int STARTUP_PERIODS = 500;
    localparam logic [8:0] STARTUP_CYCLES = 9'(STARTUP_PERIODS * MASTER_CLKS_PER_PERIOD);
    localparam logic [8:0] CODE_DLY_MULT = 9'h010;
    localparam logic [8:0] CODE_DLY_OFS = 9'h006;

    typedef enum logic [1:0] {CLAMP_NONE, CLAMP_BOTH, CLAMP_MAX, CLAMP_MIN} clamp_mode_t;
    typedef enum logic {PH_START, PH_RUN} run_phase_t;

    typedef struct packed {
        logic [31:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

endpackage

// ==== design/pwm_oscillator_core.sv ====
// Purpose: Digital PWM oscillator core with divider select and APB control
// Assumes: ref_clk is the master oscillator; inputs synchronous to it
// Notes: Functional notes follow
`timescale 1ns/1ps

module pwm_oscillator_core
    import pwm_core_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [9:0] duty_control_level,
    input wire logic [3:0] divider_select_code,
    input wire apb_req_t apb_req,
    output apb_rsp_t apb_rsp,
    output logic pwm_out
);

    typedef struct packed {
        run_phase_t phase;
        logic [8:0] start_cnt;
        logic [3:0] code;
        logic [3:0] cand;
        logic [8:0] filt_cnt;
        logic polarity_invert_bit;
        logic [14:0] per_cnt;
        logic [14:0] per_len;
        logic [14:0] high_len;
        logic [9:0] duty;
        logic pwm;
        clamp_mode_t clamp_mode;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } core_state_t;

    core_state_t st_r;
    core_state_t st_nxt;

    // ----------------------------------------
    // Decoding helpers
    // ----------------------------------------
    function automatic logic [14:0] ratio_of(input logic [3:0] c);
        logic [2:0] k;
        k = c[3] ? ~c[2:0] : c[2:0];
        return 15'(15'h0001 << (RATIO_LOG_STEP * int'(k)));
    endfunction

    function automatic logic [8:0] code_delay(input logic [3:0] a, input logic [3:0] b);
        logic [3:0] d;
        d = (a > b) ? 4'(a - b) : 4'(b - a);
        return 9'(CODE_DLY_MULT * (9'(d) + CODE_DLY_OFS));
    endfunction

    function automatic logic [9:0] duty_of(input logic [9:0] lvl, input clamp_mode_t m);
        logic [9:0] c;
        logic [12:0] p;
        logic [9:0] d;
        c = (lvl < LVL_LO) ? LVL_LO : ((lvl > LVL_HI) ? LVL_HI : lvl);
        p = 13'(13'(c - LVL_LO) * DUTY_NUM);
        d = 10'(p / DUTY_DEN);
        if ((m == CLAMP_BOTH || m == CLAMP_MIN) && d < DUTY_MIN_CLAMP) begin
            d = DUTY_MIN_CLAMP;
        end
        if ((m == CLAMP_BOTH || m == CLAMP_MAX) && d > DUTY_MAX_CLAMP) begin
            d = DUTY_MAX_CLAMP;
        end
        return d;
    endfunction

    function automatic logic addr_mapped(input logic [31:0] a);
        return a == ADDR_CTRL || a == ADDR_STATUS || a == ADDR_DUTY;
    endfunction

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    logic [9:0] duty_cmd;
    logic [14:0] ratio_cur;
    logic [24:0] high_prod;
    logic [31:0] rd;

    always_comb begin
        st_nxt = st_r;
        duty_cmd = duty_of(duty_control_level, st_r.clamp_mode);
        ratio_cur = ratio_of(st_r.code);
        high_prod = 25'(25'(duty_cmd) * 25'(ratio_cur));
        rd = '0;

        case (st_r.phase)
            PH_START: begin
                st_nxt.pwm = 1'b0;
                if (divider_select_code != st_r.cand) begin
                    st_nxt.cand = divider_select_code;
                    st_nxt.start_cnt = '0;
                end else if (st_r.start_cnt == STARTUP_CYCLES - 9'h001) begin
                    st_nxt.phase = PH_RUN;
                    st_nxt.code = st_r.cand;
                    st_nxt.polarity_invert_bit = st_r.cand[3];
                    st_nxt.per_cnt = '0;
                    st_nxt.per_len = ratio_of(st_r.cand);
                    st_nxt.duty = duty_cmd;
                    st_nxt.high_len =
                        15'(25'(25'(duty_cmd) * 25'(ratio_of(st_r.cand))) / DUTY_FULL);
                    // Count zero is shown now, else the first high phase loses a cycle
                    st_nxt.pwm = (st_nxt.high_len != 15'h0000) ^ st_r.cand[3];
                end else begin
                    st_nxt.start_cnt = 9'(st_r.start_cnt + 9'h001);
                end
            end
            PH_RUN: begin
                // Code filter: a candidate must hold still for the whole wait
                if (divider_select_code != st_r.cand) begin
                    st_nxt.cand = divider_select_code;
                    st_nxt.filt_cnt = '0;
                end else if (st_r.cand != st_r.code) begin
                    if (st_r.filt_cnt == code_delay(st_r.cand, st_r.code) - 9'h001) begin
                        st_nxt.code = st_r.cand;
                        st_nxt.filt_cnt = '0;
                    end else begin
                        st_nxt.filt_cnt = 9'(st_r.filt_cnt + 9'h001);
                    end
                end else begin
                    st_nxt.filt_cnt = '0;
                end
                // Ratio, polarity and duty only change at a period boundary
                if (st_r.per_cnt >= st_r.per_len - 15'h0001) begin
                    st_nxt.per_cnt = '0;
                    st_nxt.per_len = ratio_cur;
                    st_nxt.polarity_invert_bit = st_r.code[3];
                    st_nxt.duty = duty_cmd;
                    st_nxt.high_len = 15'(high_prod / DUTY_FULL);
                end else begin
                    st_nxt.per_cnt = 15'(st_r.per_cnt + 15'h0001);
                end
                // Full duty gives high_len == per_len, zero duty gives 0: no toggling
                st_nxt.pwm = (st_nxt.per_cnt < st_nxt.high_len) ^ st_nxt.polarity_invert_bit;
            end
            default: begin
                st_nxt.phase = PH_START;
                st_nxt.pwm = 1'b0;
            end
        endcase

        // APB slave: one wait-free access phase, response built in setup
        st_nxt.pready = 1'b0;
        st_nxt.pslverr = 1'b0;
        if (apb_req.psel && !apb_req.penable) begin
            st_nxt.pready = 1'b1;
            st_nxt.pslverr = !addr_mapped(apb_req.paddr);
            if (apb_req.paddr == ADDR_CTRL) begin
                rd[CTRL_MODE_LSB +: 2] = st_r.clamp_mode;
            end else if (apb_req.paddr == ADDR_STATUS) begin
                rd[ST_RUN_BIT] = (st_r.phase == PH_RUN);
                rd[ST_CODE_LSB +: 4] = st_r.code;
                rd[ST_POL_BIT] = st_r.polarity_invert_bit;
                rd[ST_PEND_BIT] = (st_r.cand != st_r.code);
            end else if (apb_req.paddr == ADDR_DUTY) begin
                rd[DUTY_LSB +: 10] = st_r.duty;
            end
            st_nxt.prdata = apb_req.pwrite ? 32'h0000_0000 : rd;
        end else if (apb_req.psel && apb_req.penable && st_r.pready) begin
            if (apb_req.pwrite && apb_req.paddr == ADDR_CTRL) begin
                st_nxt.clamp_mode = clamp_mode_t'(apb_req.pwdata[CTRL_MODE_LSB +: 2]);
            end
            st_nxt.prdata = '0;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pwm_out = st_r.pwm;
    assign apb_rsp.prdata = st_r.prdata;
    assign apb_rsp.pready = st_r.pready;
    assign apb_rsp.pslverr = st_r.pslverr;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_START_LOW: assert property (@(posedge ref_clk) disable iff (sys_rst)
        st_r.phase == PH_START |-> !pwm_out)
        else $error("output not low during start-up");

    AST_START_LEN: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(st_r.phase == PH_RUN) |-> $past(st_r.start_cnt) == STARTUP_CYCLES - 9'h001)
        else $error("start-up length wrong");

    AST_START_STABLE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        st_r.phase == PH_START && divider_select_code != st_r.cand
        |=> st_r.phase == PH_START && st_r.start_cnt == 9'h000)
        else $error("start-up ended on unsettled code");

    AST_CODE_DELAY: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $past(st_r.phase) == PH_RUN && $changed(st_r.code)
        |-> $past(st_r.filt_cnt) == code_delay($past(st_r.cand), $past(st_r.code)) - 9'h001)
        else $error("code adopted at wrong time");

    AST_CODE_DIRECT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $past(st_r.phase) == PH_RUN && $changed(st_r.code)
        |-> st_r.code == $past(st_r.cand) && $past(st_r.cand) == $past(divider_select_code))
        else $error("intermediate or unstable code adopted");

    AST_PERIOD_WRAP: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $past(st_r.phase) == PH_RUN && st_r.per_cnt == 15'h0000
        |-> $past(st_r.per_cnt) == $past(st_r.per_len) - 15'h0001)
        else $error("period cut short");

    AST_POL_SRC: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $past(st_r.phase) == PH_RUN && st_r.per_cnt == 15'h0000
        |-> st_r.polarity_invert_bit == $past(st_r.code[3]) && st_r.per_len == ratio_of($past(st_r.code)))
        else $error("polarity or ratio not from code");

    AST_OUT_SHAPE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        st_r.phase == PH_RUN |-> pwm_out == ((st_r.per_cnt < st_r.high_len) ^ st_r.polarity_invert_bit))
        else $error("output does not follow high count");

    AST_CLAMP_BOTH: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $past(st_r.phase) == PH_RUN && st_r.per_cnt == 15'h0000
        && $past(st_r.clamp_mode) == CLAMP_BOTH
        |-> st_r.duty >= DUTY_MIN_CLAMP && st_r.duty <= DUTY_MAX_CLAMP)
        else $error("two-sided clamp violated");

    AST_APB_READY: assert property (@(posedge ref_clk) disable iff (sys_rst)
        apb_req.psel && !apb_req.penable |=> apb_rsp.pready ##1 !apb_rsp.pready)
        else $error("APB answer not one cycle after setup");

    AST_RST_OUT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $past(sys_rst) |-> !pwm_out && !apb_rsp.pready && st_r.phase == PH_START)
        else $error("outputs not idle after reset");

    AST_CNT_RANGE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        st_r.phase == PH_RUN |-> st_r.per_cnt < st_r.per_len)
        else $error("period counter beyond period length");

    AST_HIGH_RANGE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        st_r.phase == PH_RUN |-> st_r.high_len <= st_r.per_len)
        else $error("high count longer than period");

    AST_ZERO_REST: assert property (@(posedge ref_clk) disable iff (sys_rst)
        st_r.phase == PH_RUN && st_r.high_len == 15'h0000 |-> pwm_out == st_r.polarity_invert_bit)
        else $error("output toggles at zero duty");

    AST_FULL_REST: assert property (@(posedge ref_clk) disable iff (sys_rst)
        st_r.phase == PH_RUN && st_r.high_len == st_r.per_len |-> pwm_out == !st_r.polarity_invert_bit)
        else $error("output toggles at full duty");

    AST_CLAMP_MAX: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $past(st_r.phase) == PH_RUN && st_r.per_cnt == 15'h0000
        && $past(st_r.clamp_mode) == CLAMP_MAX |-> st_r.duty <= DUTY_MAX_CLAMP)
        else $error("upper clamp violated");

    AST_CLAMP_MIN: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $past(st_r.phase) == PH_RUN && st_r.per_cnt == 15'h0000
        && $past(st_r.clamp_mode) == CLAMP_MIN |-> st_r.duty >= DUTY_MIN_CLAMP)
        else $error("lower clamp violated");

    AST_DUTY_SPAN: assert property (@(posedge ref_clk) disable iff (sys_rst)
        st_r.phase == PH_RUN |-> 25'(st_r.duty) <= DUTY_FULL)
        else $error("duty beyond full scale");

    AST_FILT_RESTART: assert property (@(posedge ref_clk) disable iff (sys_rst)
        st_r.phase == PH_RUN && divider_select_code != st_r.cand |=> st_r.filt_cnt == 9'h000)
        else $error("code filter not restarted on change");

    AST_CODE_START: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(st_r.phase == PH_RUN)
        |-> st_r.code == $past(st_r.cand) && st_r.polarity_invert_bit == $past(st_r.cand[3]))
        else $error("start-up did not adopt the settled code");

    AST_PERIOD_FIRST: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(st_r.phase == PH_RUN)
        |-> st_r.per_cnt == 15'h0000 && pwm_out == ((st_r.high_len != 15'h0000) ^ st_r.polarity_invert_bit))
        else $error("first period does not start at count zero");

    AST_RATIO_STABLE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $past(st_r.phase) == PH_RUN && st_r.per_cnt != 15'h0000
        |-> $stable(st_r.per_len) && $stable(st_r.polarity_invert_bit) && $stable(st_r.high_len))
        else $error("ratio or duty changed inside a period");

    AST_APB_ERR_QUAL: assert property (@(posedge ref_clk) disable iff (sys_rst)
        apb_rsp.pslverr |-> apb_rsp.pready)
        else $error("error flag without ready");

    AST_APB_IDLE_DATA: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !apb_rsp.pready |-> apb_rsp.prdata == 32'h0000_0000)
        else $error("read data not zero outside an answer");

    AST_READY_CAUSE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        apb_rsp.pready |-> $past(apb_req.psel && !apb_req.penable))
        else $error("ready without a setup cycle");

    AST_MODE_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite
        && apb_req.paddr == ADDR_CTRL
        |=> st_r.clamp_mode == clamp_mode_t'($past(apb_req.pwdata[CTRL_MODE_LSB +: 2])))
        else $error("clamp mode write lost");

    AST_MODE_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !(apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite)
        |=> $stable(st_r.clamp_mode))
        else $error("clamp mode changed without a write");

endmodule // pwm_oscillator_core

// ==== test/pwm_far_side.sv ====
// Purpose: Far-side model: duty control level and divider-select network
// Assumes: The bench sets the wanted level and code; both settle per cycle
// Notes: Registered so that every change lands just after a rising edge
`timescale 1ns/1ps

module pwm_far_side (
    input wire logic ref_clk,
    input wire logic [9:0] lvl_set,
    input wire logic [3:0] code_set,
    output logic [9:0] duty_control_level,
    output logic [3:0] divider_select_code
);
    // Resistor network settles to one 4-bit code; no wander between codes
    always_ff @(posedge ref_clk) begin
        duty_control_level <= lvl_set;
        divider_select_code <= code_set;
    end
endmodule // pwm_far_side

// ==== test/pwm_oscillator_core_tb_top.sv ====
// Purpose: Self-checking bench for the PWM oscillator core
// Assumes: One ref_clk cycle is one master period
// Notes: APB answers are checked by a monitor against a queue of notes
`timescale 1ns/1ps

module pwm_oscillator_core_tb_top;
    import pwm_core_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [9:0] lvl = 10'h1F4;
    logic [3:0] code = 4'h3;
    logic [9:0] duty_control_level;
    logic [3:0] divider_select_code;
    apb_req_t req = '0;
    apb_rsp_t rsp;
    logic pwm_out;
    int error_cnt = 0;
    int n_checks = 0;
    logic [65:0] note_q[$];

    always #2 ref_clk = ~ref_clk;

    pwm_far_side i_pwm_far_side (.ref_clk(ref_clk), .lvl_set(lvl), .code_set(code),
        .duty_control_level(duty_control_level), .divider_select_code(divider_select_code));
    pwm_oscillator_core i_pwm_oscillator_core (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .duty_control_level(duty_control_level), .divider_select_code(divider_select_code),
        .apb_req(req), .apb_rsp(rsp), .pwm_out(pwm_out));

    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (!ok) begin
            error_cnt++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Note holds {mask, expected {pslverr, prdata}}
    always @(posedge ref_clk) begin
        if (req.psel && req.penable && rsp.pready === 1'b1) begin
            logic [65:0] n;
            n = note_q.pop_front();
            chk((({rsp.pslverr, rsp.prdata} ^ n[32:0]) & n[65:33]) === 33'h0, "apb answer");
        end
    end

    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       input logic [32:0] e, input logic [32:0] m);
        int n;
        note_q.push_back({m, e});
        @(posedge ref_clk);
        req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: d};
        @(posedge ref_clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        chk(n < 20, "no pready");
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    function automatic int exp_duty(input int l, input int m);
        int d;
        d = ((l < 100) ? 0 : ((l > 900) ? 800 : l - 100)) * 5 / 4;
        if ((m == 1 || m == 3) && d < 50) d = 50;
        if ((m == 1 || m == 2) && d > 950) d = 950;
        return d;
    endfunction

    // Four periods of ratio 64 make the count independent of phase
    task automatic sweep(input bit p);
        int lv[6];
        int d;
        int h;
        lv = '{0, 90, 140, 500, 860, 1023};
        lv[3] = $urandom_range(1023, 0);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, ADDR_CTRL, 32'(m), 33'h0, 33'h1_0000_0000);
            for (int i = 0; i < 6; i++) begin
                @(posedge ref_clk);
                lvl <= 10'(lv[i]);
                repeat (140) @(posedge ref_clk);
                d = exp_duty(lv[i], m);
                h = 0;
                repeat (256) begin
                    @(posedge ref_clk);
                    h += int'(pwm_out === 1'b1);
                end
                chk(h == 4 * (p ? 64 - d * 64 / 1000 : d * 64 / 1000), "high count");
                apb(1'b0, ADDR_DUTY, 32'h0, 33'(d), 33'h1_0000_03FF);
            end
        end
        $display("test sweep pol %0d done", p);
    endtask

    initial begin
        int n;
        int h;
        int d;
        void'($urandom(32'hAB3B3586));
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        fork
            apb(1'b0, ADDR_STATUS, 32'h0, 33'h0, 33'h1_0000_0001);
            begin
                n = 0;
                while (pwm_out !== 1'b1 && n < 600) begin
                    @(posedge ref_clk);
                    n++;
                end
            end
        join
        chk(n >= 500 && n <= 506, "start-up length");
        h = 0;
        while (pwm_out === 1'b1 && h < 70) begin
            @(posedge ref_clk);
            h++;
        end
        chk(h == 32, "first pulse width");
        $display("test start-up done");
        apb(1'b0, ADDR_STATUS, 32'h0, 33'h031, 33'h1_0000_03FF);
        apb(1'b0, 32'h0000_0010, 32'h0, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
        sweep(1'b0);
        @(posedge ref_clk);
        code <= 4'hC;
        repeat (200) @(posedge ref_clk);
        apb(1'b0, ADDR_STATUS, 32'h0, 33'h231, 33'h1_0000_03FF);
        // Polarity follows the code only at the next period boundary
        repeat (140) @(posedge ref_clk);
        apb(1'b0, ADDR_STATUS, 32'h0, 33'h1C1, 33'h1_0000_03FF);
        sweep(1'b1);
        // Level chosen so that ratio 4 and ratio 64 give different high counts
        @(posedge ref_clk);
        code <= 4'hE;
        lvl <= 10'h1CC;
        repeat (400) @(posedge ref_clk);
        d = exp_duty(460, 3);
        h = 0;
        repeat (256) begin
            @(posedge ref_clk);
            h += int'(pwm_out === 1'b1);
        end
        chk(h == 64 * (4 - d * 4 / 1000), "ratio four high count");
        apb(1'b0, ADDR_STATUS, 32'h0, 33'h1E1, 33'h1_0000_03FF);
        $display("test ratio change done");
        finish_test();
    end

    initial begin
        repeat (60000) @(posedge ref_clk);
        error_cnt++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        finish_test();
    end
endmodule // pwm_oscillator_core_tb_top
